// ### sdst_top.sv
// Overview of operation
// RL1: all supply, reference and ground detections run while in active or sleep mode
// RL2: analog supply overvoltage or oscillation failure sets its bit in flags a
// RL3: analog undervoltage disables digital supply, resets logic, then sets reset indicator
// RL4: digital undervoltage only triggers a digital reset, no flag is set
// RL5: digital overvoltage, comm over/undervoltage set their bits in flags a
// RL6: thermistor reference faults set flags b and force temperature flags to ones
// RL7: negative rail undervoltage sets its bit in flags b
// RL8: high reference oscillation sets the reference oscillation bit in flags b
// RL9: open reference return, digital or comm ground sets its open bit in flags a
// RL10: over/undervoltage may also raise the matching oscillation flag
// RL11: host starts the self-test by writing one to the go bit
// RL12: self-test forces each path failing and checks flag and pin requests
// RL13: after each path the self-test clears flags, releases pin, moves on
// RL14: self-test never aborts; overall result lands in the self-test fail bit
// RL15: keep-flags option skips per-path clearing so silent paths stay zero
// RL16: fault pin toggles during self-test unless pin enable is cleared; code: held low with keep set, released with mask set
// RL17: with thermistor reference disabled its self-test results are ignored
// RL18: host enables the thermistor reference before starting the self-test
// RL19: host masks non-supply faults before starting the self-test
// RL20: host confirms no supply fault is present before starting the self-test
// RL21: with pin enable zero the summary flag still sets, pin stays released
// RL22: a detected supply flag stays set until host clear, reset or self-test
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sdst_top
	import sdst_pkg::*;
#(
	parameter int unsigned NT = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [NDET-1:0]   comparator_fail,
	input  wire logic              device_run,
	output logic                   fault_out_n,
	output logic                   digital_reset_req,
	output logic                   digital_supply_disable
);
	typedef struct packed {
		logic [NPATH-1:0] flags;
		logic             sfail;
		logic [NT-1:0]    overtemp_flags;
		logic [NT-1:0]    undertemp_flags;
		logic             keep;
		logic             pin_en;
		logic             ts_en;
		logic             mask;
		logic             analog_uv_reset_flag;
		sdst_st_type      st;
		logic [3:0]       path;
		logic             fail_acc;
		logic             pin_n;
		logic             drst;
		logic             dsup_off;
		logic             aw_hold;
		logic [7:0]       aw_addr;
		logic             w_hold;
		logic [31:0]      w_data;
		logic [3:0]       w_strb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} sdst_state_type;

	sdst_state_type state_reg;
	sdst_state_type state_next;

	sdst_det_if #(.W(NDET)) det_bus ();

	assign det_bus.raw = comparator_fail;

	sdst_sync #(.W(NDET)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.det     (det_bus)
	);

	// comparator outputs regrouped into flag order
	function automatic logic [NPATH-1:0] det_to_req(input logic [NDET-1:0] d);
		logic [NPATH-1:0] r;
		r             = '0;
		r[FL_AV_OV]   = d[DET_AV_OV];
		r[FL_AV_OSC]  = d[DET_AV_OSC];
		r[FL_DV_OV]   = d[DET_DV_OV];
		r[FL_CV_OV]   = d[DET_CV_OV];
		r[FL_CV_UV]   = d[DET_CV_UV];
		r[FL_RR_OPEN] = d[DET_RR_OPEN];
		r[FL_DG_OPEN] = d[DET_DG_OPEN];
		r[FL_CG_OPEN] = d[DET_CG_OPEN];
		r[FL_TS_OV]   = d[DET_TS_OV];
		r[FL_TS_UV]   = d[DET_TS_UV];
		r[FL_TS_OSC]  = d[DET_TS_OSC];
		r[FL_NEG_UV]  = d[DET_NEG_UV];
		r[FL_REF_OSC] = d[DET_REF_OSC];
		return r;
	endfunction

	function automatic logic is_ts_path(input logic [3:0] p);
		return (p == 4'(FL_TS_OV)) || (p == 4'(FL_TS_UV)) || (p == 4'(FL_TS_OSC));
	endfunction

	logic [NDET-1:0]  det;
	logic [NPATH-1:0] set_req;
	logic [NPATH-1:0] force_vec;
	logic [NPATH-1:0] ts_bits;
	logic [31:0]      wmask;
	logic [31:0]      wbits;
	logic [31:0]      rd_word;
	logic             rd_ok;
	logic             wr_ok;
	logic             uv_reset;
	logic             ts_event;
	logic             pin_req;
	logic             path_pass;

	always_comb begin
		state_next = state_reg;
		det        = device_run ? det_bus.clean : '0; // [RL1]
		ts_bits    = '0;
		ts_bits[FL_TS_OV]  = 1'b1;
		ts_bits[FL_TS_UV]  = 1'b1;
		ts_bits[FL_TS_OSC] = 1'b1;
		force_vec  = '0;
		if (state_reg.st == ST_FORCE) begin
			force_vec[state_reg.path] = 1'b1; // [RL12]
		end
		// oscillation bits are taken as they come; ov/uv may drag them along [RL10]
		set_req    = det_to_req(det) | force_vec; // [RL2] [RL5] [RL7] [RL8] [RL9]
		if (!state_reg.ts_en) begin
			set_req = set_req & ~ts_bits;
		end
		ts_event   = |(set_req & ts_bits);
		uv_reset   = det[DET_AV_UV] | det[DET_DV_UV];
		path_pass  = 1'b0;
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{state_reg.w_strb[i]}};
		end
		wbits      = state_reg.w_data & wmask;
		wr_ok      = 1'b0;
		rd_ok      = 1'b0;
		rd_word    = '0;
		state_next.drst = 1'b0;

		// read side: one request outstanding, answered the cycle after acceptance
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		unique case (s_axi_araddr[7:2])
			OFF_FLAGS_A[7:2]: begin
				rd_ok   = 1'b1;
				rd_word = 32'(state_reg.flags[FLA_WIDTH-1:0]);
			end
			OFF_FLAGS_B[7:2]: begin
				rd_ok   = 1'b1;
				rd_word = 32'({state_reg.sfail, state_reg.flags[NPATH-1:FLB_BASE]});
			end
			OFF_OT[7:2]: begin
				rd_ok   = 1'b1;
				rd_word = 32'(state_reg.overtemp_flags);
			end
			OFF_UT[7:2]: begin
				rd_ok   = 1'b1;
				rd_word = 32'(state_reg.undertemp_flags);
			end
			OFF_CTRL[7:2]: begin
				rd_ok   = 1'b1;
				rd_word[CTRL_KEEP]   = state_reg.keep;
				rd_word[CTRL_PIN_EN] = state_reg.pin_en;
				rd_word[CTRL_TS_EN]  = state_reg.ts_en;
				rd_word[CTRL_BUSY]   = (state_reg.st != ST_IDLE);
			end
			OFF_MASK[7:2]: begin
				rd_ok   = 1'b1;
				rd_word[MASK_SUPPLY] = state_reg.mask;
			end
			OFF_SUMMARY[7:2]: begin
				rd_ok   = 1'b1;
				rd_word[SUM_SUPPLY] = (|state_reg.flags | state_reg.sfail) & ~state_reg.mask;
			end
			OFF_RST_STAT[7:2]: begin
				rd_ok   = 1'b1;
				rd_word[RST_AV_UV] = state_reg.analog_uv_reset_flag;
			end
			default: begin
				rd_ok   = 1'b0;
			end
		endcase
		if (s_axi_arvalid && !state_reg.rvalid) begin
			state_next.rvalid = 1'b1;
			state_next.rdata  = rd_word;
			state_next.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// write side: address and data caught in either order, response after both
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (s_axi_awvalid && !state_reg.aw_hold && !state_reg.bvalid) begin
			state_next.aw_hold = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.w_hold && !state_reg.bvalid) begin
			state_next.w_hold = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_strb = s_axi_wstrb;
		end
		if (state_reg.aw_hold && state_reg.w_hold && !state_reg.bvalid) begin
			state_next.aw_hold = 1'b0;
			state_next.w_hold  = 1'b0;
			state_next.bvalid  = 1'b1;
			wr_ok              = 1'b1;
			unique case (state_reg.aw_addr[7:2])
				OFF_FLAGS_A[7:2]: begin
					state_next.flags[FLA_WIDTH-1:0] =
						state_reg.flags[FLA_WIDTH-1:0] & ~wbits[FLA_WIDTH-1:0];
				end
				OFF_FLAGS_B[7:2]: begin
					state_next.flags[NPATH-1:FLB_BASE] =
						state_reg.flags[NPATH-1:FLB_BASE] & ~wbits[FLB_WIDTH-1:0];
					state_next.sfail = state_reg.sfail & ~wbits[FLB_SFAIL];
				end
				OFF_OT[7:2]: begin
					state_next.overtemp_flags = state_reg.overtemp_flags & ~wbits[NT-1:0];
				end
				OFF_UT[7:2]: begin
					state_next.undertemp_flags = state_reg.undertemp_flags & ~wbits[NT-1:0];
				end
				OFF_CTRL[7:2]: begin
					if (state_reg.w_strb[0]) begin
						state_next.keep   = state_reg.w_data[CTRL_KEEP];
						state_next.pin_en = state_reg.w_data[CTRL_PIN_EN];
						state_next.ts_en  = state_reg.w_data[CTRL_TS_EN];
						// go is self-clearing and ignored while a run is under way [RL11]
						if (state_reg.w_data[CTRL_GO] && state_reg.st == ST_IDLE) begin
							state_next.st       = ST_FORCE;
							state_next.path     = '0;
							state_next.fail_acc = 1'b0;
						end
					end
				end
				OFF_MASK[7:2]: begin
					if (state_reg.w_strb[0]) begin
						state_next.mask = state_reg.w_data[MASK_SUPPLY];
					end
				end
				OFF_RST_STAT[7:2]: begin
					state_next.analog_uv_reset_flag =
						state_reg.analog_uv_reset_flag & ~wbits[RST_AV_UV];
				end
				OFF_SUMMARY[7:2]: begin
					wr_ok = 1'b1;
				end
				default: begin
					wr_ok = 1'b0;
				end
			endcase
			state_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// self-test sequencer, walks every covered path regardless of failures [RL14]
		unique case (state_reg.st)
			ST_IDLE: begin
				// fail_acc untouched so the clear done by a go write survives
				path_pass = 1'b0;
			end
			ST_FORCE: begin
				// flag set request and unmasked pin request must both be up [RL12]
				path_pass = set_req[state_reg.path] & ~state_reg.mask;
				if (!path_pass && !(is_ts_path(state_reg.path) && !state_reg.ts_en)) begin // [RL17]
					state_next.fail_acc = 1'b1;
				end
				state_next.st = ST_CLEAR;
			end
			ST_CLEAR: begin
				if (!state_reg.keep) begin
					state_next.flags = '0; // [RL13]
				end
				// with keep set the flags survive so a silent path reads zero [RL15]
				if (state_reg.path == PATH_LAST) begin
					state_next.st    = ST_IDLE;
					state_next.sfail = state_reg.fail_acc; // [RL14]
				end else begin
					state_next.path = state_reg.path + 4'h1; // [RL13]
					state_next.st   = ST_FORCE;
				end
			end
		endcase

		// hardware sets come after host and self-test clears so they win over those in the same cycle; the uv reset below still wipes them [RL22]
		state_next.flags = state_next.flags | set_req;
		if (ts_event) begin
			state_next.overtemp_flags  = '1; // [RL6]
			state_next.undertemp_flags = '1; // [RL6]
		end

		// undervoltage reset wipes block state but not the bus handshake [RL3] [RL4]
		state_next.dsup_off = det[DET_AV_UV]; // [RL3]
		if (uv_reset) begin
			state_next.flags           = '0;
			state_next.sfail           = 1'b0;
			state_next.overtemp_flags  = '0;
			state_next.undertemp_flags = '0;
			state_next.keep            = RST_KEEP;
			state_next.pin_en          = RST_PIN_EN;
			state_next.ts_en           = RST_TS_EN;
			state_next.mask            = RST_MASK;
			state_next.st              = ST_IDLE;
			state_next.path            = '0;
			state_next.fail_acc        = 1'b0;
			state_next.drst            = 1'b1; // [RL4]
			if (det[DET_AV_UV]) begin
				state_next.analog_uv_reset_flag = 1'b1; // [RL3]
			end
		end

		// pin follows unmasked flags and so toggles per self-test path while keep is clear [RL16]
		pin_req          = (|state_next.flags | state_next.sfail) & ~state_next.mask;
		state_next.pin_n = ~(pin_req & state_next.pin_en); // [RL21]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg                      <= '0;
			state_reg.keep                 <= RST_KEEP;
			state_reg.pin_en               <= RST_PIN_EN;
			state_reg.ts_en                <= RST_TS_EN;
			state_reg.mask                 <= RST_MASK;
			state_reg.st                   <= ST_IDLE;
			state_reg.pin_n                <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign s_axi_awready          = ~state_reg.aw_hold & ~state_reg.bvalid;
	assign s_axi_wready           = ~state_reg.w_hold & ~state_reg.bvalid;
	assign s_axi_bvalid           = state_reg.bvalid;
	assign s_axi_bresp            = state_reg.bresp;
	assign s_axi_arready          = ~state_reg.rvalid;
	assign s_axi_rvalid           = state_reg.rvalid;
	assign s_axi_rdata            = state_reg.rdata;
	assign s_axi_rresp            = state_reg.rresp;
	assign fault_out_n            = state_reg.pin_n;
	assign digital_reset_req      = state_reg.drst;
	assign digital_supply_disable = state_reg.dsup_off;
endmodule

// ### sdst_pkg.sv
package sdst_pkg;

	// comparator input bit positions on the raw detection bus
	localparam int unsigned NDET         = 15;
	localparam int unsigned DET_AV_OV    = 0;
	localparam int unsigned DET_AV_UV    = 1;
	localparam int unsigned DET_AV_OSC   = 2;
	localparam int unsigned DET_DV_OV    = 3;
	localparam int unsigned DET_DV_UV    = 4;
	localparam int unsigned DET_CV_OV    = 5;
	localparam int unsigned DET_CV_UV    = 6;
	localparam int unsigned DET_TS_OV    = 7;
	localparam int unsigned DET_TS_UV    = 8;
	localparam int unsigned DET_TS_OSC   = 9;
	localparam int unsigned DET_NEG_UV   = 10;
	localparam int unsigned DET_REF_OSC  = 11;
	localparam int unsigned DET_RR_OPEN  = 12;
	localparam int unsigned DET_DG_OPEN  = 13;
	localparam int unsigned DET_CG_OPEN  = 14;

	// flag vector: bits 0..7 are supply_fault_flags_a, bits 8..12 are flags_b[4:0]
	localparam int unsigned NPATH        = 13;
	localparam int unsigned FL_AV_OV     = 0;
	localparam int unsigned FL_AV_OSC    = 1;
	localparam int unsigned FL_DV_OV     = 2;
	localparam int unsigned FL_CV_OV     = 3;
	localparam int unsigned FL_CV_UV     = 4;
	localparam int unsigned FL_RR_OPEN   = 5;
	localparam int unsigned FL_DG_OPEN   = 6;
	localparam int unsigned FL_CG_OPEN   = 7;
	localparam int unsigned FL_TS_OV     = 8;
	localparam int unsigned FL_TS_UV     = 9;
	localparam int unsigned FL_TS_OSC    = 10;
	localparam int unsigned FL_NEG_UV    = 11;
	localparam int unsigned FL_REF_OSC   = 12;
	localparam int unsigned FLB_BASE     = 8;
	localparam int unsigned FLA_WIDTH    = 8;
	localparam int unsigned FLB_WIDTH    = 5;
	localparam int unsigned FLB_SFAIL    = 5;
	localparam logic [3:0]  PATH_LAST    = 4'hc;

	// register byte offsets
	localparam logic [7:0] OFF_FLAGS_A   = 8'h00;
	localparam logic [7:0] OFF_FLAGS_B   = 8'h04;
	localparam logic [7:0] OFF_OT        = 8'h08;
	localparam logic [7:0] OFF_UT        = 8'h0c;
	localparam logic [7:0] OFF_CTRL      = 8'h10;
	localparam logic [7:0] OFF_MASK      = 8'h14;
	localparam logic [7:0] OFF_SUMMARY   = 8'h18;
	localparam logic [7:0] OFF_RST_STAT  = 8'h1c;

	// supply_diag_control fields
	localparam int unsigned CTRL_GO      = 0;
	localparam int unsigned CTRL_KEEP    = 1;
	localparam int unsigned CTRL_PIN_EN  = 2;
	localparam int unsigned CTRL_TS_EN   = 3;
	localparam int unsigned CTRL_BUSY    = 4;
	localparam logic        RST_KEEP     = 1'b0;
	localparam logic        RST_PIN_EN   = 1'b1;
	localparam logic        RST_TS_EN    = 1'b1;
	localparam logic        RST_MASK     = 1'b0;

	localparam int unsigned MASK_SUPPLY  = 0;
	localparam int unsigned SUM_SUPPLY   = 0;
	localparam int unsigned RST_AV_UV    = 0;

	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FORCE = 3'b010,
		ST_CLEAR = 3'b100
	} sdst_st_type;

endpackage

// ### sdst_det_if.sv
`timescale 1ns/1ps
interface sdst_det_if #(
	parameter int unsigned W = 15
);
	logic [W-1:0] raw;
	logic [W-1:0] clean;

	modport sync_end (input raw, output clean);
	modport core_end (output raw, input clean);
endinterface

// ### sdst_sync.sv
`timescale 1ns/1ps
module sdst_sync #(
	parameter int unsigned W = 15
) (
	input  wire logic   aclk,
	input  wire logic   aresetn,
	sdst_det_if.sync_end det
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] clean;
	} sdst_sync_type;

	sdst_sync_type state_reg;
	sdst_sync_type state_next;

	always_comb begin
		state_next    = state_reg;
		state_next.s1 = det.raw;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		// a bit moves only once stages two and three agree, so one-cycle glitches drop out
		for (int i = 0; i < W; i++) begin
			if (state_reg.s2[i] == state_reg.s3[i]) begin
				state_next.clean[i] = state_reg.s3[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign det.clean = state_reg.clean;
endmodule

// ### sdst_checker.sv
`timescale 1ns/1ps
module sdst_checker
	import sdst_pkg::*;
(
	input wire logic            aclk,
	input wire logic            aresetn,
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic            s_axi_wvalid,
	input wire logic            s_axi_wready,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready,
	input wire logic [NDET-1:0] comparator_fail,
	input wire logic            device_run,
	input wire logic            digital_reset_req,
	input wire logic            digital_supply_disable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// seven cycles covers the three sync flops, the clean stage and the output register
	AST_DV_UV_RESET: assert property (
		(device_run && comparator_fail[DET_DV_UV])[*7] |-> digital_reset_req)
		else $error("digital uv gave no reset request");
	AST_AV_UV_DISABLE: assert property (
		(device_run && comparator_fail[DET_AV_UV])[*7] |-> digital_supply_disable && digital_reset_req)
		else $error("analog uv gave no disable");
	AST_AV_UV_RELEASE: assert property (
		(!comparator_fail[DET_AV_UV])[*7] |-> !digital_supply_disable)
		else $error("supply disable without analog uv");
	AST_STOPPED_QUIET: assert property (
		(!device_run)[*7] |-> !digital_reset_req && !digital_supply_disable)
		else $error("reset action outside active or sleep");
	AST_B_FOLLOWS: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_B_DROPS: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_R_FOLLOWS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_DROPS: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read data repeated");
endmodule
bind sdst_top sdst_checker sdst_checker_inst (.*);

// ### sdst_host_model.sv
`timescale 1ns/1ps
module sdst_host_model
	import sdst_pkg::*;
(
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic [2:0]       s_axi_awprot,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic [2:0]       s_axi_arprot,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// ready lines stay high, so back-to-back calls never drive them twice
	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arprot, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready} = 2'b11;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic start_st(input logic [31:0] ctl);
		logic [31:0] d;
		logic [1:0]  r;
		// only supply faults exist here, nothing else to mask
		do rd(OFF_SUMMARY, d, r); while (d[SUM_SUPPLY] !== 1'b0);
		wr(OFF_CTRL, ctl | 32'h1, r);
	endtask
endmodule

// ### sdst_top_tb.sv
`timescale 1ns/1ps
module sdst_top_tb;
	import sdst_pkg::*;
	logic            aclk, aresetn, device_run, fault_out_n, pin_d;
	logic            digital_reset_req, digital_supply_disable;
	logic [NDET-1:0] comparator_fail;
	logic [7:0]      s_axi_awaddr, s_axi_araddr;
	logic [2:0]      s_axi_awprot, s_axi_arprot;
	logic [31:0]     s_axi_wdata, s_axi_rdata, d;
	logic [3:0]      s_axi_wstrb;
	logic [1:0]      s_axi_bresp, s_axi_rresp, r;
	logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic            s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int              errors, checks_done, falls;
	sdst_top sdst_top_inst (.*);
	sdst_host_model sdst_host_model_inst (.*);
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		pin_d <= fault_out_n;
		if (pin_d === 1'b1 && fault_out_n === 1'b0) falls <= falls + 1;
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		sdst_host_model_inst.rd(a, d, r);
		chk(d & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		sdst_host_model_inst.wr(a, v, r);
	endtask
	task automatic hold(input int b, input int n);
		comparator_fail[b] <= 1'b1;
		repeat (n) @(posedge aclk);
		comparator_fail[b] <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	task automatic clr_all;
		wr(OFF_FLAGS_A, 32'hff);
		wr(OFF_FLAGS_B, 32'h3f);
		wr(OFF_OT, 32'hffff);
		wr(OFF_UT, 32'hffff);
		wr(OFF_RST_STAT, 32'h1);
	endtask
	task automatic run_st(input logic [31:0] ctl);
		falls = 0;
		sdst_host_model_inst.start_st(ctl);
		rd_chk(OFF_CTRL, 32'h11, 32'h10);
		do sdst_host_model_inst.rd(OFF_CTRL, d, r); while (d[CTRL_BUSY] !== 1'b0);
	endtask
	task automatic t_reset;
		chk(fault_out_n, 1'b1);
		rd_chk(OFF_CTRL, 32'h1f, 32'h0c);
		rd_chk(OFF_FLAGS_A, 32'hff, 32'h0);
		rd_chk(8'h20, 32'hffffffff, 32'h0);
		chk(r, RESP_SLVERR);
		wr(8'h20, 32'h1);
		chk(r, RESP_SLVERR);
	endtask
	task automatic t_flags;
		// detection bit feeding each flag path, in flag order
		int det [13] = '{0, 2, 3, 5, 6, 12, 13, 14, 7, 8, 9, 10, 11};
		for (int p = 0; p < 13; p++) begin
			hold(det[p], 3);
			rd_chk(p < 8 ? OFF_FLAGS_A : OFF_FLAGS_B, 1 << p % 8, 1 << p % 8);
			chk(fault_out_n, 1'b0);
			if (p >= 8 && p <= 10) begin
				rd_chk(OFF_OT, 32'hffff, 32'hffff);
				rd_chk(OFF_UT, 32'hffff, 32'hffff);
			end
			clr_all;
			repeat (2) @(posedge aclk);
			chk(fault_out_n, 1'b1);
		end
	endtask
	task automatic t_uv;
		comparator_fail[DET_DV_UV] <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(digital_reset_req, 1'b1);
		chk(digital_supply_disable, 1'b0);
		comparator_fail[DET_DV_UV] <= 1'b0;
		comparator_fail[DET_AV_UV] <= 1'b1;
		repeat (8) @(posedge aclk);
		chk({digital_supply_disable, digital_reset_req}, 2'b11);
		rd_chk(OFF_FLAGS_A, 32'h01, 32'h0);
		comparator_fail[DET_AV_UV] <= 1'b0;
		repeat (8) @(posedge aclk);
		rd_chk(OFF_RST_STAT, 32'h1, 32'h1);
		clr_all;
		rd_chk(OFF_RST_STAT, 32'h1, 32'h0);
	endtask
	task automatic t_idle;
		device_run <= 1'b0;
		hold(DET_CV_OV, 3);
		rd_chk(OFF_FLAGS_A, 32'hff, 32'h0);
		device_run <= 1'b1;
		hold(DET_CV_UV, 3);
		rd_chk(OFF_FLAGS_A, 32'hff, 32'h10);
		clr_all;
	endtask
	task automatic t_pin_off;
		wr(OFF_CTRL, 32'h08);
		hold(DET_CV_OV, 3);
		chk(fault_out_n, 1'b1);
		rd_chk(OFF_SUMMARY, 32'h1, 32'h1);
		clr_all;
		wr(OFF_CTRL, 32'h0c);
	endtask
	task automatic t_st_pass;
		run_st(32'h0c);
		chk(falls, 13);
		rd_chk(OFF_FLAGS_B, 32'h3f, 32'h0);
		rd_chk(OFF_FLAGS_A, 32'hff, 32'h0);
		clr_all;
	endtask
	task automatic t_st_keep;
		run_st(32'h0e);
		rd_chk(OFF_FLAGS_A, 32'hff, 32'hff);
		rd_chk(OFF_FLAGS_B, 32'h3f, 32'h1f);
		clr_all;
	endtask
	task automatic t_st_mask;
		wr(OFF_MASK, 32'h1);
		run_st(32'h0c);
		chk(falls, 0);
		rd_chk(OFF_FLAGS_B, 32'h20, 32'h20);
		wr(OFF_MASK, 32'h0);
		clr_all;
	endtask
	task automatic t_st_no_ts;
		run_st(32'h02);
		chk(falls, 0);
		rd_chk(OFF_FLAGS_B, 32'h3f, 32'h18);
		clr_all;
		wr(OFF_CTRL, 32'h0c);
	endtask
	initial begin
		{aresetn, comparator_fail, errors, checks_done, falls} = '0;
		device_run = 1'b1;
		pin_d = 1'b1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_flags;
		t_uv;
		t_idle;
		t_pin_off;
		t_st_pass;
		t_st_keep;
		t_st_mask;
		t_st_no_ts;
		tally_and_finish;
	end
	// whole run needs well under a thousand cycles
	initial begin
		repeat (30000) @(posedge aclk);
		errors++;
		$display("[ERR] %0t watchdog %h %h", $time, checks_done, errors);
		tally_and_finish;
	end
endmodule
